/* File: sfcfg_pkg.sv */
// Purpose: shared constants for the serial port frame configuration block
// Assumes: register indices; byte address is four times the index
// Notes:   one register per aligned 32-bit word, data in the low byte
package sfcfg_pkg;
	// register indices
	localparam logic [3:0] IDX_RX_CONTROL   = 4'h6;
	localparam logic [3:0] IDX_FRAME_FORMAT = 4'h7;
	localparam logic [3:0] IDX_DIVISOR_LOW  = 4'h8;
	localparam logic [3:0] IDX_DIVISOR_HIGH = 4'h9;
	localparam logic [3:0] IDX_AB_WINDOW    = 4'hA;
	localparam int         BYTE_ADDR_SHIFT  = 2;

	// receiver control fields
	localparam int         POS_MULTIPROC    = 0;
	localparam int         POS_RX_MODE      = 1;
	localparam logic [7:0] RST_RX_CONTROL   = 8'h00;

	// frame format fields
	localparam int         POS_COMM_MODE    = 6;
	localparam int         POS_PARITY       = 4;
	localparam int         POS_STOP_BITS    = 3;
	localparam int         POS_CHAR_WIDTH   = 0;
	localparam int         POS_BIT_ORDER    = 2;
	localparam int         POS_CLOCK_PHASE  = 1;
	localparam logic [7:0] RST_FRAME_NORMAL = 8'h03;
	localparam logic [7:0] RST_FRAME_SPI    = 8'h00;

	// divisor and window
	localparam logic [15:0] RST_DIVISOR     = 16'h0000;
	localparam int          POS_AB_WINDOW   = 6;
	localparam logic [7:0]  RST_AB_WINDOW   = 8'h00;
	localparam int          NOMINAL_PAIR    = 32;

	typedef enum logic [1:0] {
		SFCFG_ASYNC, SFCFG_SYNC, SFCFG_INFRARED, SFCFG_HOST_SPI
	} sfcfg_comm_t;

	typedef enum logic [1:0] {
		SFCFG_RX_NORMAL, SFCFG_RX_DOUBLE, SFCFG_RX_GEN_AUTO, SFCFG_RX_LIN_AUTO
	} sfcfg_rxmode_t;

	localparam logic [1:0] PAR_NONE = 2'h0;
	localparam logic [1:0] PAR_EVEN = 2'h2;
	localparam logic [1:0] PAR_ODD  = 2'h3;

	localparam logic [2:0] CW_NINE_LOW  = 3'h6;
	localparam logic [2:0] CW_NINE_HIGH = 3'h7;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: sfcfg_top.sv */
// Purpose: frame, divisor and auto-baud window configuration of a serial port
// Assumes: AXI4-Lite slave, one clock, inputs synchronous to clk_sys_in
// Notes:   decoded settings feed the shifter and receiver outside this block
// Notes on behaviour
// - multiproc_enable set turns multiprocessor mode on
// - mode field selects async, sync, infrared, SPI
// - mode 3 switches to SPI field layout
// - other modes restore parity, stop, size layout
// - parity none, even at 2, odd at 3
// - transmitter sends one or two stop bits
// - receiver ignores stop bit setting
// - char width codes 0..3 give 5..8 bits
// - codes 6, 7 give nine bits, byte order
// - SPI bit order zero msb first
// - SPI clock phase selects sampling edge
// - divisor is sixteen bits, low then high
// - divisor write reloads the prescaler immediately
// - LIN auto-baud judges samples per bit pair
// - window code sets accepted pair count
// - receiver mode 3 is LIN auto-baud
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
module sfcfg_top #(
	parameter int ADDR_W  = 6,
	parameter int COUNT_W = 8
) (
	input  wire logic                clk_sys_in,
	input  wire logic                rst_b_in,
	// axi4-lite slave
	input  wire logic [ADDR_W-1:0]   s_axi_awaddr_in,
	input  wire logic                s_axi_awvalid_in,
	output logic                     s_axi_awready_out,
	input  wire logic [31:0]         s_axi_wdata_in,
	input  wire logic [3:0]          s_axi_wstrb_in,
	input  wire logic                s_axi_wvalid_in,
	output logic                     s_axi_wready_out,
	output logic [1:0]               s_axi_bresp_out,
	output logic                     s_axi_bvalid_out,
	input  wire logic                s_axi_bready_in,
	input  wire logic [ADDR_W-1:0]   s_axi_araddr_in,
	input  wire logic                s_axi_arvalid_in,
	output logic                     s_axi_arready_out,
	output logic [31:0]              s_axi_rdata_out,
	output logic [1:0]               s_axi_rresp_out,
	output logic                     s_axi_rvalid_out,
	input  wire logic                s_axi_rready_in,
	// decoded settings
	output logic                     multiproc_enable_out,
	output logic                     async_mode_out,
	output logic                     sync_mode_out,
	output logic                     infrared_mode_out,
	output logic                     host_spi_mode_out,
	output logic                     parity_enable_out,
	output logic                     parity_odd_out,
	output logic [1:0]               tx_stop_bits_out,
	output logic [1:0]               rx_stop_bits_out,
	output logic [3:0]               char_bits_out,
	output logic                     nine_bit_low_first_out,
	output logic                     nine_bit_high_first_out,
	output logic                     bit_order_lsb_first_out,
	output logic                     clock_phase_trailing_out,
	output logic [15:0]              divisor_out,
	output logic                     baud_tick_out,
	output logic                     lin_autobaud_mode_out,
	// auto-baud window check
	input  wire logic [COUNT_W-1:0]  pair_count_in,
	input  wire logic                pair_count_valid_in,
	output logic                     window_ok_out,
	output logic                     window_mismatch_out
);
	if (ADDR_W < 6) begin : g_chk_addr
		$error("sfcfg_top: ADDR_W must be at least 6");
	end
	if (COUNT_W < 6) begin : g_chk_count
		$error("sfcfg_top: COUNT_W must hold 32+8");
	end

	// tolerance in samples for each window code
	function automatic logic [3:0] window_tol(input logic [1:0] code);
		unique case (code)
			2'h0: window_tol = 4'h6;
			2'h1: window_tol = 4'h5;
			2'h2: window_tol = 4'h7;
			2'h3: window_tol = 4'h8;
		endcase
	endfunction

	function automatic logic [3:0] reg_index(input logic [ADDR_W-1:0] addr);
		reg_index = addr[sfcfg_pkg::BYTE_ADDR_SHIFT +: 4];
	endfunction

	function automatic logic idx_mapped(input logic [ADDR_W-1:0] addr);
		logic [3:0] idx;
		idx = reg_index(addr);
		idx_mapped = ((addr >> (sfcfg_pkg::BYTE_ADDR_SHIFT + 4)) == '0) &&
			(idx >= sfcfg_pkg::IDX_RX_CONTROL) && (idx <= sfcfg_pkg::IDX_AB_WINDOW);
	endfunction

	// register state
	logic       multiproc_q;
	logic [1:0] rx_mode_q;
	logic [1:0] comm_mode_q;
	logic [1:0] parity_q;
	logic       stop_bits_q;
	logic [2:0] char_width_q;
	logic       bit_order_q;
	logic       clock_phase_q;
	logic [15:0] divisor_q;
	logic [1:0] ab_window_q;

	// write channel capture
	logic              aw_held_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic              w_held_q;
	logic [7:0]        w_byte_q;
	logic              w_lane0_q;
	logic              bvalid_q;
	logic [1:0]        bresp_q;
	logic              wr_commit;
	logic [3:0]        wr_idx;
	logic              wr_en;

	assign s_axi_awready_out = !aw_held_q && !bvalid_q;
	assign s_axi_wready_out  = !w_held_q && !bvalid_q;
	assign wr_commit         = aw_held_q && w_held_q && !bvalid_q;
	assign wr_idx            = reg_index(aw_addr_q);
	assign wr_en             = wr_commit && idx_mapped(aw_addr_q) && w_lane0_q;
	assign s_axi_bvalid_out  = bvalid_q;
	assign s_axi_bresp_out   = bresp_q;

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			aw_held_q <= 1'b0;
			aw_addr_q <= '0;
		end else if (s_axi_awvalid_in && s_axi_awready_out) begin
			aw_held_q <= 1'b1;
			aw_addr_q <= s_axi_awaddr_in;
		end else if (wr_commit) begin
			aw_held_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			w_held_q  <= 1'b0;
			w_byte_q  <= 8'h00;
			w_lane0_q <= 1'b0;
		end else if (s_axi_wvalid_in && s_axi_wready_out) begin
			w_held_q  <= 1'b1;
			w_byte_q  <= s_axi_wdata_in[7:0];
			w_lane0_q <= s_axi_wstrb_in[0];
		end else if (wr_commit) begin
			w_held_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			bvalid_q <= 1'b0;
			bresp_q  <= sfcfg_pkg::RESP_OKAY;
		end else if (wr_commit) begin
			bvalid_q <= 1'b1;
			bresp_q  <= idx_mapped(aw_addr_q) ? sfcfg_pkg::RESP_OKAY : sfcfg_pkg::RESP_SLVERR;
		end else if (s_axi_bready_in) begin
			bvalid_q <= 1'b0;
		end
	end

	// receiver control
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			multiproc_q <= sfcfg_pkg::RST_RX_CONTROL[sfcfg_pkg::POS_MULTIPROC];
			rx_mode_q   <= sfcfg_pkg::RST_RX_CONTROL[sfcfg_pkg::POS_RX_MODE +: 2];
		end else if (wr_en && wr_idx == sfcfg_pkg::IDX_RX_CONTROL) begin
			multiproc_q <= w_byte_q[sfcfg_pkg::POS_MULTIPROC];
			rx_mode_q   <= w_byte_q[sfcfg_pkg::POS_RX_MODE +: 2];
		end
	end

	// frame format: the written mode picks which field set is stored
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			comm_mode_q   <= sfcfg_pkg::RST_FRAME_NORMAL[sfcfg_pkg::POS_COMM_MODE +: 2];
			parity_q      <= sfcfg_pkg::RST_FRAME_NORMAL[sfcfg_pkg::POS_PARITY +: 2];
			stop_bits_q   <= sfcfg_pkg::RST_FRAME_NORMAL[sfcfg_pkg::POS_STOP_BITS];
			char_width_q  <= sfcfg_pkg::RST_FRAME_NORMAL[sfcfg_pkg::POS_CHAR_WIDTH +: 3];
			bit_order_q   <= sfcfg_pkg::RST_FRAME_SPI[sfcfg_pkg::POS_BIT_ORDER];
			clock_phase_q <= sfcfg_pkg::RST_FRAME_SPI[sfcfg_pkg::POS_CLOCK_PHASE];
		end else if (wr_en && wr_idx == sfcfg_pkg::IDX_FRAME_FORMAT) begin
			comm_mode_q <= w_byte_q[sfcfg_pkg::POS_COMM_MODE +: 2];
			if (w_byte_q[sfcfg_pkg::POS_COMM_MODE +: 2] == 2'(sfcfg_pkg::SFCFG_HOST_SPI)) begin
				bit_order_q   <= w_byte_q[sfcfg_pkg::POS_BIT_ORDER];
				clock_phase_q <= w_byte_q[sfcfg_pkg::POS_CLOCK_PHASE];
			end else begin
				parity_q     <= w_byte_q[sfcfg_pkg::POS_PARITY +: 2];
				stop_bits_q  <= w_byte_q[sfcfg_pkg::POS_STOP_BITS];
				char_width_q <= w_byte_q[sfcfg_pkg::POS_CHAR_WIDTH +: 3];
			end
		end
	end

	// divisor, one byte per index
	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			divisor_q <= sfcfg_pkg::RST_DIVISOR;
		end else if (wr_en && wr_idx == sfcfg_pkg::IDX_DIVISOR_LOW) begin
			divisor_q[7:0] <= w_byte_q;
		end else if (wr_en && wr_idx == sfcfg_pkg::IDX_DIVISOR_HIGH) begin
			divisor_q[15:8] <= w_byte_q;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ab_window_q <= sfcfg_pkg::RST_AB_WINDOW[sfcfg_pkg::POS_AB_WINDOW +: 2];
		end else if (wr_en && wr_idx == sfcfg_pkg::IDX_AB_WINDOW) begin
			ab_window_q <= w_byte_q[sfcfg_pkg::POS_AB_WINDOW +: 2];
		end
	end

	// baud prescaler, reloaded by any divisor write
	logic [15:0] presc_q;
	logic        tick_q;
	logic        div_write;
	logic [15:0] div_new;

	assign div_write = wr_en && (wr_idx == sfcfg_pkg::IDX_DIVISOR_LOW ||
		wr_idx == sfcfg_pkg::IDX_DIVISOR_HIGH);
	assign div_new   = (wr_idx == sfcfg_pkg::IDX_DIVISOR_LOW) ?
		{divisor_q[15:8], w_byte_q} : {w_byte_q, divisor_q[7:0]};

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			presc_q <= sfcfg_pkg::RST_DIVISOR;
			tick_q  <= 1'b0;
		end else if (div_write) begin
			presc_q <= div_new;
			tick_q  <= 1'b0;
		end else if (presc_q == 16'h0000) begin
			presc_q <= divisor_q;
			tick_q  <= 1'b1;
		end else begin
			presc_q <= presc_q - 16'h0001;
			tick_q  <= 1'b0;
		end
	end

	// auto-baud window check on each bit pair reported while receiver mode is LIN auto-baud
	logic             lin_mode;
	logic [COUNT_W-1:0] win_lo;
	logic [COUNT_W-1:0] win_hi;
	logic             ok_q;
	logic             mismatch_q;

	assign lin_mode = (rx_mode_q == 2'(sfcfg_pkg::SFCFG_RX_LIN_AUTO));
	assign win_lo   = COUNT_W'(sfcfg_pkg::NOMINAL_PAIR) - COUNT_W'(window_tol(ab_window_q));
	assign win_hi   = COUNT_W'(sfcfg_pkg::NOMINAL_PAIR) + COUNT_W'(window_tol(ab_window_q));

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ok_q       <= 1'b0;
			mismatch_q <= 1'b0;
		end else begin
			ok_q       <= 1'b0;
			mismatch_q <= 1'b0;
			if (pair_count_valid_in && lin_mode) begin
				if (pair_count_in >= win_lo && pair_count_in <= win_hi) begin
					ok_q <= 1'b1;
				end else begin
					mismatch_q <= 1'b1;
				end
			end
		end
	end

	// read channel
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic [7:0]  rd_byte;
	logic [3:0]  rd_idx;

	assign s_axi_arready_out = !rvalid_q;
	assign s_axi_rvalid_out  = rvalid_q;
	assign s_axi_rdata_out   = rdata_q;
	assign s_axi_rresp_out   = rresp_q;
	assign rd_idx            = reg_index(s_axi_araddr_in);

	always_comb begin
		rd_byte = 8'h00;
		if (rd_idx == sfcfg_pkg::IDX_RX_CONTROL) begin
			rd_byte[sfcfg_pkg::POS_MULTIPROC]   = multiproc_q;
			rd_byte[sfcfg_pkg::POS_RX_MODE +: 2] = rx_mode_q;
		end else if (rd_idx == sfcfg_pkg::IDX_FRAME_FORMAT) begin
			rd_byte[sfcfg_pkg::POS_COMM_MODE +: 2] = comm_mode_q;
			if (comm_mode_q == 2'(sfcfg_pkg::SFCFG_HOST_SPI)) begin
				rd_byte[sfcfg_pkg::POS_BIT_ORDER]   = bit_order_q;
				rd_byte[sfcfg_pkg::POS_CLOCK_PHASE] = clock_phase_q;
			end else begin
				rd_byte[sfcfg_pkg::POS_PARITY +: 2]     = parity_q;
				rd_byte[sfcfg_pkg::POS_STOP_BITS]       = stop_bits_q;
				rd_byte[sfcfg_pkg::POS_CHAR_WIDTH +: 3] = char_width_q;
			end
		end else if (rd_idx == sfcfg_pkg::IDX_DIVISOR_LOW) begin
			rd_byte = divisor_q[7:0];
		end else if (rd_idx == sfcfg_pkg::IDX_DIVISOR_HIGH) begin
			rd_byte = divisor_q[15:8];
		end else if (rd_idx == sfcfg_pkg::IDX_AB_WINDOW) begin
			rd_byte[sfcfg_pkg::POS_AB_WINDOW +: 2] = ab_window_q;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h00000000;
			rresp_q  <= sfcfg_pkg::RESP_OKAY;
		end else if (s_axi_arvalid_in && !rvalid_q) begin
			rvalid_q <= 1'b1;
			if (idx_mapped(s_axi_araddr_in)) begin
				rdata_q <= {24'h000000, rd_byte};
				rresp_q <= sfcfg_pkg::RESP_OKAY;
			end else begin
				rdata_q <= 32'h00000000;
				rresp_q <= sfcfg_pkg::RESP_SLVERR;
			end
		end else if (s_axi_rready_in) begin
			rvalid_q <= 1'b0;
		end
	end

	// decoded settings
	logic spi_mode;
	assign spi_mode = (comm_mode_q == 2'(sfcfg_pkg::SFCFG_HOST_SPI));

	assign multiproc_enable_out     = multiproc_q;
	assign async_mode_out           = (comm_mode_q == 2'(sfcfg_pkg::SFCFG_ASYNC));
	assign sync_mode_out            = (comm_mode_q == 2'(sfcfg_pkg::SFCFG_SYNC));
	assign infrared_mode_out        = (comm_mode_q == 2'(sfcfg_pkg::SFCFG_INFRARED));
	assign host_spi_mode_out        = spi_mode;
	// reserved parity code treated as disabled
	assign parity_enable_out        = !spi_mode && (parity_q == sfcfg_pkg::PAR_EVEN ||
		parity_q == sfcfg_pkg::PAR_ODD);
	assign parity_odd_out           = !spi_mode && (parity_q == sfcfg_pkg::PAR_ODD);
	assign tx_stop_bits_out         = stop_bits_q ? 2'h2 : 2'h1;
	assign rx_stop_bits_out         = 2'h1;
	assign nine_bit_low_first_out   = !spi_mode && (char_width_q == sfcfg_pkg::CW_NINE_LOW);
	assign nine_bit_high_first_out  = !spi_mode && (char_width_q == sfcfg_pkg::CW_NINE_HIGH);
	assign bit_order_lsb_first_out  = spi_mode && bit_order_q;
	assign clock_phase_trailing_out = spi_mode && clock_phase_q;
	assign divisor_out              = divisor_q;
	assign baud_tick_out            = tick_q;
	assign lin_autobaud_mode_out    = lin_mode;
	assign window_ok_out            = ok_q;
	assign window_mismatch_out      = mismatch_q;

	always_comb begin
		unique case (char_width_q)
			3'h0: char_bits_out = 4'h5;
			3'h1: char_bits_out = 4'h6;
			3'h2: char_bits_out = 4'h7;
			3'h3: char_bits_out = 4'h8;
			3'h6, 3'h7: char_bits_out = 4'h9;
			default: char_bits_out = 4'h8;
		endcase
	end
endmodule // sfcfg_top

/* File: sfcfg_props.sv */
// Purpose: concurrent checks on the decoded frame settings
// Assumes: one clock, reset active low
// Notes:   bound into sfcfg_top
`timescale 1ns/1ps
module sfcfg_props #(
	parameter int COUNT_W = 8
) (
	input wire logic               clk_sys_in,
	input wire logic               rst_b_in,
	input wire logic               async_mode_out,
	input wire logic               sync_mode_out,
	input wire logic               infrared_mode_out,
	input wire logic               host_spi_mode_out,
	input wire logic               parity_enable_out,
	input wire logic               parity_odd_out,
	input wire logic [1:0]         tx_stop_bits_out,
	input wire logic [1:0]         rx_stop_bits_out,
	input wire logic [3:0]         char_bits_out,
	input wire logic               nine_bit_low_first_out,
	input wire logic               nine_bit_high_first_out,
	input wire logic               bit_order_lsb_first_out,
	input wire logic               clock_phase_trailing_out,
	input wire logic [15:0]        divisor_out,
	input wire logic               baud_tick_out,
	input wire logic               lin_autobaud_mode_out,
	input wire logic [COUNT_W-1:0] pair_count_in,
	input wire logic               pair_count_valid_in,
	input wire logic               window_ok_out,
	input wire logic               window_mismatch_out
);
	logic take;
	assign take = pair_count_valid_in && lin_autobaud_mode_out;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);
	property p_onehot; $onehot({async_mode_out, sync_mode_out, infrared_mode_out, host_spi_mode_out}); endproperty
	a_onehot: assert property (p_onehot)
		else $error("mode outputs not one-hot");
	property p_spi; host_spi_mode_out |-> !parity_enable_out && !nine_bit_low_first_out && !nine_bit_high_first_out; endproperty
	a_spi: assert property (p_spi)
		else $error("frame fields active in spi mode");
	property p_norm; !host_spi_mode_out |-> !bit_order_lsb_first_out && !clock_phase_trailing_out; endproperty
	a_norm: assert property (p_norm)
		else $error("spi fields active in normal mode");
	property p_par; parity_odd_out |-> parity_enable_out; endproperty
	a_par: assert property (p_par)
		else $error("odd parity without parity enable");
	property p_stop; tx_stop_bits_out inside {2'h1, 2'h2} && rx_stop_bits_out == 2'h1; endproperty
	a_stop: assert property (p_stop)
		else $error("stop bit outputs out of range");
	property p_nine; char_bits_out inside {[4'h5:4'h9]} && !(nine_bit_low_first_out && nine_bit_high_first_out) && (host_spi_mode_out || ((nine_bit_low_first_out || nine_bit_high_first_out) == (char_bits_out == 4'h9))); endproperty
	a_nine: assert property (p_nine)
		else $error("character width and nine bit order disagree");
	property p_reload; $changed(divisor_out) |-> !baud_tick_out ##1 (divisor_out == 16'h0000 || !baud_tick_out); endproperty
	a_reload: assert property (p_reload)
		else $error("tick too soon after divisor load");
	property p_narrow; take && pair_count_in inside {[27:37]} |=> window_ok_out && !window_mismatch_out; endproperty
	a_narrow: assert property (p_narrow)
		else $error("count near nominal not accepted");
	property p_wide; take && (pair_count_in < 24 || pair_count_in > 40) |=> window_mismatch_out && !window_ok_out; endproperty
	a_wide: assert property (p_wide)
		else $error("count far from nominal not refused");
	property p_idle; !take |=> !window_ok_out && !window_mismatch_out; endproperty
	a_idle: assert property (p_idle)
		else $error("window result without lin measurement");
	c_spi: cover property (host_spi_mode_out);
	c_mis: cover property (take ##1 window_mismatch_out);
	c_div: cover property ($changed(divisor_out));
endmodule // sfcfg_props

bind sfcfg_top sfcfg_props #(.COUNT_W(COUNT_W)) sfcfg_props_i (
	.clk_sys_in, .rst_b_in, .async_mode_out, .sync_mode_out, .infrared_mode_out,
	.host_spi_mode_out, .parity_enable_out, .parity_odd_out, .tx_stop_bits_out,
	.rx_stop_bits_out, .char_bits_out, .nine_bit_low_first_out, .nine_bit_high_first_out,
	.bit_order_lsb_first_out, .clock_phase_trailing_out, .divisor_out, .baud_tick_out,
	.lin_autobaud_mode_out, .pair_count_in, .pair_count_valid_in, .window_ok_out,
	.window_mismatch_out
);

/* File: sfcfg_remote_model.sv */
// Purpose: remote sender timing, one bit pair sample count per call
// Assumes: driven from the bench clock
// Notes:   count line shows garbage outside the valid cycle
`timescale 1ns/1ps
module sfcfg_remote_model #(
	parameter int COUNT_W = 8
) (
	input  wire logic               clk_sys_in,
	output logic [COUNT_W-1:0]      pair_count_out,
	output logic                    pair_valid_out
);
	initial begin
		pair_count_out = '0;
		pair_valid_out = 1'b0;
	end
	task automatic send(input logic [COUNT_W-1:0] c);
		@(posedge clk_sys_in);
		pair_count_out <= c;
		pair_valid_out <= 1'b1;
		@(posedge clk_sys_in);
		pair_valid_out <= 1'b0;
		pair_count_out <= ~c;
	endtask
endmodule // sfcfg_remote_model

/* File: sfcfg_top_tb.sv */
// Purpose: self-checking bench for the frame configuration block
// Assumes: 20 MHz clock, register byte address four times the index
// Notes:   remote model supplies the auto-baud pair counts
`timescale 1ns/1ps
module sfcfg_top_tb;
	logic        clk_sys_in = 1'b0;
	logic        rst_b_in = 1'b0;
	logic [5:0]  s_axi_awaddr_in = 6'h00, s_axi_araddr_in = 6'h00;
	logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
	logic [3:0]  s_axi_wstrb_in = 4'hF;
	logic        s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
	logic        s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0, s_axi_rvalid_out;
	logic        s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
	logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, tx_stop_bits_out, rx_stop_bits_out;
	logic        multiproc_enable_out, async_mode_out, sync_mode_out, infrared_mode_out;
	logic        host_spi_mode_out, parity_enable_out, parity_odd_out, nine_bit_low_first_out;
	logic        nine_bit_high_first_out, bit_order_lsb_first_out, clock_phase_trailing_out;
	logic        baud_tick_out, lin_autobaud_mode_out, window_ok_out, window_mismatch_out;
	logic        pair_count_valid_in;
	logic [3:0]  char_bits_out;
	logic [7:0]  pair_count_in, d;
	logic [15:0] divisor_out;
	int          mismatches = 0, check_count = 0, r, c;
	integer      seed = 32'h23D4;
	logic [7:0]  spiv [4] = '{8'hFF, 8'hC2, 8'hC4, 8'hC0};
	int          tol [4] = '{6, 5, 7, 8};

	always #25 clk_sys_in = ~clk_sys_in;

	sfcfg_top sfcfg_top_i (.clk_sys_in, .rst_b_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
		.s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in,
		.s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out, .s_axi_bready_in,
		.s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out,
		.s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .multiproc_enable_out,
		.async_mode_out, .sync_mode_out, .infrared_mode_out, .host_spi_mode_out,
		.parity_enable_out, .parity_odd_out, .tx_stop_bits_out, .rx_stop_bits_out,
		.char_bits_out, .nine_bit_low_first_out, .nine_bit_high_first_out,
		.bit_order_lsb_first_out, .clock_phase_trailing_out, .divisor_out, .baud_tick_out,
		.lin_autobaud_mode_out, .pair_count_in, .pair_count_valid_in, .window_ok_out,
		.window_mismatch_out);
	sfcfg_remote_model sfcfg_remote_model_i (.clk_sys_in, .pair_count_out(pair_count_in),
		.pair_valid_out(pair_count_valid_in));

	function automatic logic [3:0] exp_bits(input logic [2:0] cw);
		return cw < 3'h4 ? 4'h5 + cw : (cw > 3'h5 ? 4'h9 : 4'h8);
	endfunction
	function automatic bit in_win(input int n, input int t);
		return n >= 32 - t && n <= 32 + t;
	endfunction
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] idx, input logic [7:0] v, input logic [1:0] er);
		logic [1:0] rsp;
		@(posedge clk_sys_in);
		s_axi_awaddr_in <= {idx, 2'h0};
		s_axi_wdata_in <= {24'h000000, v};
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		do begin
			@(posedge clk_sys_in);
			if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
			if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
		end while (s_axi_bvalid_out !== 1'b1);
		rsp = s_axi_bresp_out;
		s_axi_bready_in <= 1'b0;
		#1;
		chk(rsp, er);
	endtask
	task automatic rd(input logic [3:0] idx, input logic [7:0] v, input logic [1:0] er);
		logic [33:0] got;
		@(posedge clk_sys_in);
		s_axi_araddr_in <= {idx, 2'h0};
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		do begin
			@(posedge clk_sys_in);
			if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
		end while (s_axi_rvalid_out !== 1'b1);
		got = {s_axi_rresp_out, s_axi_rdata_out};
		s_axi_rready_in <= 1'b0;
		#1;
		chk(got[31:0], {24'h000000, v});
		chk(got[33:32], er);
	endtask
	task automatic frame(input logic [1:0] m, input logic [1:0] p, input logic s,
		input logic [2:0] cw);
		wr(4'h7, {m, p, s, cw}, 2'h0);
		chk({host_spi_mode_out, infrared_mode_out, sync_mode_out, async_mode_out}, 4'h1 << m);
		chk({parity_enable_out, parity_odd_out}, {p[1], p == 2'h3});
		chk({tx_stop_bits_out, rx_stop_bits_out}, {s ? 2'h2 : 2'h1, 2'h1});
		chk({char_bits_out, nine_bit_low_first_out, nine_bit_high_first_out},
			{exp_bits(cw), cw == 3'h6, cw == 3'h7});
		rd(4'h7, {m, p, s, cw}, 2'h0);
	endtask
	task automatic period(input int exp);
		int n;
		n = 0;
		@(posedge clk_sys_in);
		while (!baud_tick_out) @(posedge clk_sys_in);
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (!baud_tick_out);
		#1;
		chk(n, exp);
	endtask

	initial begin
		#(50 * 40000);
		mismatches++;
		close_out();
	end

	initial begin
		repeat (20) @(posedge clk_sys_in);
		rst_b_in <= 1'b1;
		#1;
		chk({async_mode_out, parity_enable_out, tx_stop_bits_out, char_bits_out}, 8'h98);
		rd(4'h7, 8'h03, 2'h0);
		for (int i = 6; i < 11; i++) if (i != 7) rd(4'(i), 8'h00, 2'h0);
		period(1);
		for (int i = 0; i < 24; i++) begin
			r = $random(seed);
			if (i < 8) frame(2'(i % 3), i[1:0], i[0], i[2:0]);
			else frame(r[1:0] % 2'h3, r[3:2], r[4], r[7:5]);
		end
		foreach (spiv[k]) begin
			wr(4'h7, spiv[k], 2'h0);
			chk({host_spi_mode_out, parity_enable_out, nine_bit_low_first_out}, 3'h4);
			chk({bit_order_lsb_first_out, clock_phase_trailing_out}, spiv[k][2:1]);
			rd(4'h7, spiv[k] & 8'hC6, 2'h0);
		end
		frame(2'h0, 2'h3, 1'b1, 3'h5);
		for (int k = 0; k < 3; k++) begin
			r = $random(seed);
			d = k == 0 ? 8'h0F : {4'h0, r[3:0]};
			wr(4'h8, d, 2'h0);
			chk(divisor_out, {8'h00, d});
			period(d + 1);
			wr(4'h9, 8'h12, 2'h0);
			chk(divisor_out, {8'h12, d});
			rd(4'h8, d, 2'h0);
			rd(4'h9, 8'h12, 2'h0);
			wr(4'h9, 8'h00, 2'h0);
		end
		wr(4'h6, 8'h07, 2'h0);
		chk({multiproc_enable_out, lin_autobaud_mode_out}, 2'h3);
		for (int w = 0; w < 4; w++) begin
			wr(4'hA, {w[1:0], 6'h00}, 2'h0);
			rd(4'hA, {w[1:0], 6'h00}, 2'h0);
			for (int j = 0; j < 5; j++) begin
				r = $random(seed);
				c = j == 0 ? 32 - tol[w] : j == 1 ? 32 + tol[w] : 20 + r[4:0];
				c = j == 2 ? 31 - tol[w] : j == 3 ? 33 + tol[w] : c;
				sfcfg_remote_model_i.send(c[7:0]);
				#1;
				chk({window_ok_out, window_mismatch_out}, in_win(c, tol[w]) ? 2'h2 : 2'h1);
			end
		end
		wr(4'h6, 8'h02, 2'h0);
		chk({multiproc_enable_out, lin_autobaud_mode_out}, 2'h0);
		sfcfg_remote_model_i.send(8'h20);
		#1;
		chk({window_ok_out, window_mismatch_out}, 2'h0);
		wr(4'hB, 8'h55, 2'h2);
		rd(4'h0, 8'h00, 2'h2);
		close_out();
	end
endmodule // sfcfg_top_tb
